// File: swp_pkg.sv
// Shared constants and state types of the sleep and wake power sequencer.
package swp_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int CORE_CLK_MHZ = 250;
  localparam int BROWNOUT_SAMPLING_CLOCK_MHZ = 1;
  localparam int BOD_HALF_CYCLES = CORE_CLK_MHZ / (2 * BROWNOUT_SAMPLING_CLOCK_MHZ);
  localparam int WAKE_MAX_US = 1200;
  localparam int WAKE_MAX_CYCLES = (WAKE_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int WFI_TO_LP_CYCLES = 7;
  localparam int ENTRY_LATENCY_TICKS = 4;
  localparam int LDO_SETTLE_TICKS = 12;
  localparam int WAKE_FILTER_TICKS = 2;

  localparam logic [3:0] OFS_SLEEP_PERIOD = 4'h0;
  localparam logic [3:0] OFS_CONV_CTRL = 4'h4;
  localparam logic [3:0] OFS_POWER_CONFIG = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  localparam logic [1:0] CONV_MODE_OFF = 2'h0;
  localparam logic [1:0] CONV_MODE_ACTIVE = 2'h1;
  localparam logic [1:0] CONV_MODE_SLEEP = 2'h2;

  localparam int CFG_CONVERTER = 0;
  localparam int CFG_SYS_RET = 1;
  localparam int CFG_IO_RET_A = 2;
  localparam int CFG_IO_RET_B = 3;

  localparam int ST_BOD_SEEN = 5;
  localparam int ST_WAKE_TIMEOUT = 6;
  localparam int ST_REMAP = 7;

  localparam logic [15:0] RST_SLEEP_PERIOD = 16'h0000;
  localparam logic [1:0] RST_CONV_MODE = 2'h0;
  localparam logic [3:0] RST_POWER_CONFIG = 4'h0;

  typedef enum logic [4:0] {
    PW_SLEEP_WAIT, PW_BANDGAP, PW_FAST_CLOCK, PW_BROWNOUT,
    PW_CONVERTER, PW_TRACK, PW_HOLD, PW_RETURN
  } swp_wake_e;

  typedef enum logic [2:0] {
    MS_POWER_UP, MS_RUN, MS_WFI_DELAY, MS_ENTRY, MS_SLEEP, MS_FILTER
  } swp_main_e;

endpackage

// File: swp_sequencer.sv
// Sleep and wake power sequencer with periodic intermediate wake-ups.
//
// How it works
// - Hand control to processor once fast clock enabled.
// - Boot ROM at zero; RAM remapped after wake.
// - Wake sequence bounded to 1.2 ms.
// - Sleep: low-power clock, retention on, core off.
// - Seven cycles from sleep instruction to switch.
// - Nonzero period triggers periodic bandgap sampling wake-ups.
// - Sleep entry takes four low-power clock ticks.
// - Periodic wake leaves wait into bandgap state.
// - Then fast clock state, then brown-out state.
// - Brown-out detectors sampled with 1 MHz clock.
// - Converter state charges rails only in sleep mode.
// - Track and hold refresh retention references; return ends the wake-up.
// - Only configured resources are charged or refreshed; retention enables ignore the configuration.
// - Filter wake event, then repeat power-up steps.
`timescale 1ns/100ps
`default_nettype none

module swp_sequencer #(
  parameter int WAKE_MAX_CYC = swp_pkg::WAKE_MAX_CYCLES,
  parameter int PERIOD_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic WFI_PULSE,
  input wire logic LOW_POWER_CLOCK_PIN,
  input wire logic WAKE_PIN,
  input wire logic BOD_FAIL_PIN,
  output logic CPU_RUN,
  output logic REMAP_RAM,
  output logic LP_CLOCK_SELECT,
  output logic BANDGAP_EN,
  output logic FAST_RC_EN,
  output logic BROWNOUT_SAMPLING_CLOCK,
  output logic CONVERTER_ACTIVE,
  output logic CONVERTER_CHARGE,
  output logic SYS_RET_EN,
  output logic IO_RET_A_EN,
  output logic IO_RET_B_EN,
  output logic CORE_REG_EN,
  output logic REF_TRACK,
  output logic REF_HOLD,
  output logic [4:0] WAKE_STATE
);
  import swp_pkg::*;

  logic [2:0] sync1_q, sync2_q, sync3_q, lvl_q;
  logic lp_tick, wake_lvl, bod_lvl;
  swp_main_e main_q;
  swp_wake_e wake_q;
  logic [3:0] tick_cnt_q;
  logic [2:0] wfi_cnt_q;
  logic [PERIOD_W-1:0] slp_cnt_q;
  logic [19:0] wake_cyc_q;
  logic [6:0] bod_div_q;
  logic brownout_sampling_clock_q, bod_seen_q, timeout_q, remap_q, lp_sel_q;
  logic [PERIOD_W-1:0] period_q;
  logic [1:0] conv_mode_q;
  logic [3:0] cfg_q;
  logic wake_timeout;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level changes only once the second and third stages agree.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      lvl_q <= 3'h0;
    end else begin
      sync1_q <= {BOD_FAIL_PIN, WAKE_PIN, LOW_POWER_CLOCK_PIN};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 3; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          lvl_q[i] <= sync3_q[i];
        end
      end
    end
  end

  assign lp_tick = sync2_q[0] & sync3_q[0] & ~lvl_q[0];
  assign wake_lvl = lvl_q[1];
  assign bod_lvl = lvl_q[2];
  assign wake_timeout = remap_q && (wake_cyc_q >= 20'(WAKE_MAX_CYC));

  //////////////////////////////////////////////////////////////////////////////
  // Main power sequence.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      main_q <= MS_POWER_UP;
      tick_cnt_q <= 4'h0;
      wfi_cnt_q <= 3'h0;
      remap_q <= 1'b0;
      lp_sel_q <= 1'b0;
    end else begin
      unique case (main_q)
        MS_POWER_UP: begin
          // A slow wake clock must not stretch the wake beyond its bound.
          if (wake_timeout) begin
            main_q <= MS_RUN;
            lp_sel_q <= 1'b0;
          end else if (lp_tick) begin
            if (tick_cnt_q == 4'(LDO_SETTLE_TICKS - 1)) begin
              main_q <= MS_RUN;
              lp_sel_q <= 1'b0;
            end else begin
              tick_cnt_q <= tick_cnt_q + 4'h1;
            end
          end
        end
        MS_RUN: begin
          if (WFI_PULSE) begin
            main_q <= MS_WFI_DELAY;
            wfi_cnt_q <= 3'h0;
          end
        end
        MS_WFI_DELAY: begin
          if (wfi_cnt_q == 3'(WFI_TO_LP_CYCLES - 2)) begin
            main_q <= MS_ENTRY;
            lp_sel_q <= 1'b1;
            tick_cnt_q <= 4'h0;
          end else begin
            wfi_cnt_q <= wfi_cnt_q + 3'h1;
          end
        end
        MS_ENTRY: begin
          if (lp_tick) begin
            if (tick_cnt_q == 4'(ENTRY_LATENCY_TICKS - 1)) begin
              main_q <= MS_SLEEP;
              tick_cnt_q <= 4'h0;
            end else begin
              tick_cnt_q <= tick_cnt_q + 4'h1;
            end
          end
        end
        MS_SLEEP: begin
          // A wake event waits for any periodic wake-up to finish first.
          if (wake_q == PW_SLEEP_WAIT && wake_lvl) begin
            main_q <= MS_FILTER;
            tick_cnt_q <= 4'h0;
          end
        end
        MS_FILTER: begin
          if (!wake_lvl) begin
            main_q <= MS_SLEEP;
          end else if (lp_tick) begin
            if (tick_cnt_q == 4'(WAKE_FILTER_TICKS - 1)) begin
              main_q <= MS_POWER_UP;
              remap_q <= 1'b1;
              tick_cnt_q <= 4'h0;
            end else begin
              tick_cnt_q <= tick_cnt_q + 4'h1;
            end
          end
        end
        // An illegal state code restarts the power-up sequence rather than locking up.
        default: main_q <= MS_POWER_UP;
      endcase
    end
  end

  // Wake duration counter; it only runs while a wake from sleep is being powered up.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wake_cyc_q <= 20'h0_0000;
    end else if (main_q == MS_POWER_UP && remap_q) begin
      if (!wake_timeout) begin
        wake_cyc_q <= wake_cyc_q + 20'h0_0001;
      end
    end else begin
      wake_cyc_q <= 20'h0_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Periodic intermediate wake-up, one state per low-power clock tick.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wake_q <= PW_SLEEP_WAIT;
      slp_cnt_q <= '0;
    end else if (main_q != MS_SLEEP) begin
      wake_q <= PW_SLEEP_WAIT;
      slp_cnt_q <= '0;
    end else if (lp_tick) begin
      unique case (wake_q)
        PW_SLEEP_WAIT: begin
          if (period_q == '0) begin
            slp_cnt_q <= '0;
          end else if (slp_cnt_q == period_q - PERIOD_W'(1)) begin
            slp_cnt_q <= '0;
            wake_q <= PW_BANDGAP;
          end else begin
            slp_cnt_q <= slp_cnt_q + PERIOD_W'(1);
          end
        end
        PW_BANDGAP: wake_q <= PW_FAST_CLOCK;
        PW_FAST_CLOCK: wake_q <= PW_BROWNOUT;
        PW_BROWNOUT: wake_q <= PW_CONVERTER;
        PW_CONVERTER: wake_q <= PW_TRACK;
        PW_TRACK: wake_q <= PW_HOLD;
        PW_HOLD: wake_q <= PW_RETURN;
        PW_RETURN: wake_q <= PW_SLEEP_WAIT;
        default: wake_q <= PW_SLEEP_WAIT;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Brown-out sampling clock and sticky brown-out flag.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bod_div_q <= 7'h00;
      brownout_sampling_clock_q <= 1'b0;
      bod_seen_q <= 1'b0;
    end else begin
      if (main_q == MS_SLEEP && wake_q == PW_BROWNOUT) begin
        if (bod_div_q == 7'(BOD_HALF_CYCLES - 1)) begin
          bod_div_q <= 7'h00;
          brownout_sampling_clock_q <= ~brownout_sampling_clock_q;
        end else begin
          bod_div_q <= bod_div_q + 7'h01;
        end
      end else begin
        bod_div_q <= 7'h00;
        brownout_sampling_clock_q <= 1'b0;
      end
      // A detection in the clearing cycle still sets the flag.
      if (brownout_sampling_clock_q && bod_div_q == 7'h00 && bod_lvl) begin
        bod_seen_q <= 1'b1;
      end else if (WR && ADDR == OFS_STATUS && WDATA[ST_BOD_SEEN]) begin
        bod_seen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      timeout_q <= 1'b0;
    end else if (wake_timeout) begin
      timeout_q <= 1'b1;
    end else if (WR && ADDR == OFS_STATUS && WDATA[ST_WAKE_TIMEOUT]) begin
      timeout_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      period_q <= PERIOD_W'(RST_SLEEP_PERIOD);
      conv_mode_q <= RST_CONV_MODE;
      cfg_q <= RST_POWER_CONFIG;
    end else if (WR) begin
      unique case (ADDR)
        OFS_SLEEP_PERIOD: period_q <= WDATA[PERIOD_W-1:0];
        OFS_CONV_CTRL: conv_mode_q <= WDATA[1:0];
        OFS_POWER_CONFIG: cfg_q <= WDATA[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      unique case (ADDR)
        OFS_SLEEP_PERIOD: RDATA <= 32'(period_q);
        OFS_CONV_CTRL: RDATA <= {30'h0000_0000, conv_mode_q};
        OFS_POWER_CONFIG: RDATA <= {28'h000_0000, cfg_q};
        OFS_STATUS: RDATA <= {24'h00_0000, remap_q, timeout_q, bod_seen_q, wake_q};
        default: RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered power controls decoded from the two state machines.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      CPU_RUN <= 1'b0;
      FAST_RC_EN <= 1'b0;
      BANDGAP_EN <= 1'b0;
      CORE_REG_EN <= 1'b0;
      SYS_RET_EN <= 1'b0;
      IO_RET_A_EN <= 1'b0;
      IO_RET_B_EN <= 1'b0;
      CONVERTER_ACTIVE <= 1'b0;
      CONVERTER_CHARGE <= 1'b0;
      REF_TRACK <= 1'b0;
      REF_HOLD <= 1'b0;
    end else begin
      CPU_RUN <= (main_q == MS_RUN);
      FAST_RC_EN <= (main_q == MS_RUN) ||
                    (main_q == MS_SLEEP && wake_q >= PW_FAST_CLOCK);
      BANDGAP_EN <= (main_q == MS_POWER_UP) || (main_q == MS_RUN) ||
                    (main_q == MS_WFI_DELAY) ||
                    (main_q == MS_SLEEP && wake_q != PW_SLEEP_WAIT &&
                     wake_q != PW_RETURN);
      CORE_REG_EN <= (main_q == MS_POWER_UP) || (main_q == MS_RUN) ||
                     (main_q == MS_WFI_DELAY) || (main_q == MS_ENTRY);
      SYS_RET_EN <= (main_q == MS_ENTRY) || (main_q == MS_SLEEP) ||
                    (main_q == MS_FILTER);
      IO_RET_A_EN <= (main_q == MS_ENTRY) || (main_q == MS_SLEEP) ||
                     (main_q == MS_FILTER);
      IO_RET_B_EN <= (main_q == MS_ENTRY) || (main_q == MS_SLEEP) ||
                     (main_q == MS_FILTER);
      CONVERTER_ACTIVE <= (main_q == MS_RUN) && (conv_mode_q == CONV_MODE_ACTIVE);
      CONVERTER_CHARGE <= (main_q == MS_SLEEP) && (wake_q == PW_CONVERTER) &&
                          (conv_mode_q == CONV_MODE_SLEEP) && cfg_q[CFG_CONVERTER];
      REF_TRACK <= (main_q == MS_SLEEP) && (wake_q == PW_TRACK) &&
                   (|cfg_q[CFG_IO_RET_B:CFG_SYS_RET]);
      REF_HOLD <= (main_q == MS_SLEEP) && (wake_q == PW_HOLD) &&
                  (|cfg_q[CFG_IO_RET_B:CFG_SYS_RET]);
    end
  end

  assign REMAP_RAM = remap_q;
  assign LP_CLOCK_SELECT = lp_sel_q;
  assign BROWNOUT_SAMPLING_CLOCK = brownout_sampling_clock_q;
  assign WAKE_STATE = wake_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [3:0] entry_ticks_q;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      entry_ticks_q <= 4'h0;
    end else if (main_q != MS_ENTRY) begin
      entry_ticks_q <= 4'h0;
    end else if (lp_tick) begin
      entry_ticks_q <= entry_ticks_q + 4'h1;
    end
  end

  sequence s_wfi_taken;
    main_q == MS_RUN && WFI_PULSE;
  endsequence
  sequence s_wfi_wait;
    (main_q == MS_WFI_DELAY && !lp_sel_q) [*6] ##1 (main_q == MS_ENTRY && lp_sel_q);
  endsequence

  AST_HANDOFF: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(CPU_RUN) |-> FAST_RC_EN) else $error("processor released without fast clock");
  AST_REMAP: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(REMAP_RAM) |-> $past(main_q) == MS_FILTER) else $error("remap without wake");
  AST_WAKE_BOUND: assert property (@(posedge CORE_CLK) disable iff (RST)
    wake_cyc_q == 20'(WAKE_MAX_CYC) |=> main_q == MS_RUN && timeout_q)
    else $error("wake sequence too long");
  AST_WFI_SEVEN: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_wfi_taken |=> s_wfi_wait) else $error("sleep switch not seven cycles after wfi");
  AST_RET_ON: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(main_q == MS_ENTRY) |=> SYS_RET_EN && IO_RET_A_EN && IO_RET_B_EN && CORE_REG_EN)
    else $error("retention regulators not enabled at sleep entry");
  AST_CORE_OFF: assert property (@(posedge CORE_CLK) disable iff (RST)
    main_q == MS_SLEEP |=> !CORE_REG_EN && LP_CLOCK_SELECT) else $error("core regulator on");
  AST_ENTRY_LAT: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(main_q == MS_SLEEP) && $past(main_q) == MS_ENTRY |->
    $past(entry_ticks_q) == 4'(ENTRY_LATENCY_TICKS - 1) && $past(lp_tick))
    else $error("sleep entry latency wrong");
  AST_PERIOD: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(wake_q == PW_BANDGAP) |-> period_q != '0 && $past(slp_cnt_q) == period_q - PERIOD_W'(1))
    else $error("periodic wake at wrong time");
  AST_ORDER: assert property (@(posedge CORE_CLK) disable iff (RST)
    main_q == MS_SLEEP && $changed(wake_q) |->
    (wake_q == 5'($past(wake_q) + 5'h01)) || ($past(wake_q) == PW_RETURN && wake_q == PW_SLEEP_WAIT))
    else $error("periodic state order broken");
  AST_CHARGE: assert property (@(posedge CORE_CLK) disable iff (RST)
    CONVERTER_CHARGE |-> $past(wake_q) == PW_CONVERTER && $past(conv_mode_q) == CONV_MODE_SLEEP)
    else $error("rail charge outside converter state");
  AST_BROWNOUT_SAMPLING_CLOCK: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(BROWNOUT_SAMPLING_CLOCK) |-> $past(wake_q) == PW_BROWNOUT && $past(bod_div_q) == 7'(BOD_HALF_CYCLES - 1))
    else $error("brown-out clock outside brown-out state");

endmodule

`default_nettype wire

// File: swp_far_model.sv
// Behavioural model of the processor and low-power oscillator that face the sequencer.
`timescale 1ns/100ps
`default_nettype none

module swp_far_model #(
  parameter int LP_HALF_CYC = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_req,
  input wire logic cpu_run,
  output logic low_power_clock,
  output logic wfi_pulse
);
  logic [15:0] div_q;

  // The low-power oscillator runs in every mode, so the tick source never stops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 16'h0000;
      low_power_clock <= 1'b0;
    end else if (div_q == 16'(LP_HALF_CYC - 1)) begin
      div_q <= 16'h0000;
      low_power_clock <= ~low_power_clock;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Software is already back on the fast RC clock with the crystal off when it sleeps.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wfi_pulse <= 1'b0;
    else wfi_pulse <= sleep_req && cpu_run && !wfi_pulse;
  end
endmodule
`default_nettype wire

// File: swp_sequencer_tb.sv
// Self-checking testbench of the sleep and wake power sequencer.
`timescale 1ns/100ps
`default_nettype none

module swp_sequencer_tb;
  import swp_pkg::*;
  localparam int LPH = 200;
  logic CORE_CLK, RST, WR, RD, WAKE_PIN, BOD_FAIL_PIN, WFI_PULSE, LOW_POWER_CLOCK_PIN, sleep_req;
  logic [3:0] ADDR;
  logic [31:0] WDATA, RDATA, d;
  logic CPU_RUN, REMAP_RAM, LP_CLOCK_SELECT, BANDGAP_EN, FAST_RC_EN, BROWNOUT_SAMPLING_CLOCK;
  logic CONVERTER_ACTIVE, CONVERTER_CHARGE, SYS_RET_EN, IO_RET_A_EN, IO_RET_B_EN;
  logic CORE_REG_EN, REF_TRACK, REF_HOLD;
  logic [4:0] WAKE_STATE;
  wire logic [2:0] mon;
  int bad_count, n_checks, lp_edges, e0, n;

  assign mon = {CORE_REG_EN, LP_CLOCK_SELECT, CPU_RUN};

  swp_sequencer #(.WAKE_MAX_CYC(20000)) i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WFI_PULSE(WFI_PULSE),
    .LOW_POWER_CLOCK_PIN(LOW_POWER_CLOCK_PIN), .WAKE_PIN(WAKE_PIN), .BOD_FAIL_PIN(BOD_FAIL_PIN),
    .CPU_RUN(CPU_RUN), .REMAP_RAM(REMAP_RAM), .LP_CLOCK_SELECT(LP_CLOCK_SELECT),
    .BANDGAP_EN(BANDGAP_EN), .FAST_RC_EN(FAST_RC_EN), .BROWNOUT_SAMPLING_CLOCK(BROWNOUT_SAMPLING_CLOCK),
    .CONVERTER_ACTIVE(CONVERTER_ACTIVE), .CONVERTER_CHARGE(CONVERTER_CHARGE),
    .SYS_RET_EN(SYS_RET_EN), .IO_RET_A_EN(IO_RET_A_EN), .IO_RET_B_EN(IO_RET_B_EN),
    .CORE_REG_EN(CORE_REG_EN), .REF_TRACK(REF_TRACK), .REF_HOLD(REF_HOLD),
    .WAKE_STATE(WAKE_STATE));

  swp_far_model #(.LP_HALF_CYC(LPH)) i_far (.clk(CORE_CLK), .rst(RST), .sleep_req(sleep_req),
    .cpu_run(CPU_RUN), .low_power_clock(LOW_POWER_CLOCK_PIN), .wfi_pulse(WFI_PULSE));

  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  always @(posedge LOW_POWER_CLOCK_PIN) lp_edges++;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask

  task automatic wait_for(input int b, input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge CORE_CLK);
      #1 cnt++;
    end while (mon[b] !== v && cnt < 40000);
    if (cnt >= 40000) begin
      bad_count++;
      $display("[FAIL] wait on monitor bit %0d expected %b seen %b", b, v, mon[b]);
      conclude();
    end
  endtask

  // Follows one periodic wake-up and notes which outputs were seen in which state.
  task automatic watch_wake(input logic exp_chg, input logic exp_ref);
    logic [4:0] prev;
    logic [7:0] bg, rc, chg, trk, hld;
    logic bodp;
    int seq [16];
    int t, last_tog, gap, ns;
    prev = 5'h00;
    bg = 8'h00;
    rc = 8'h00;
    chg = 8'h00;
    trk = 8'h00;
    hld = 8'h00;
    bodp = 1'b0;
    t = 0;
    last_tog = -1;
    gap = 0;
    ns = 0;
    do begin
      @(posedge CORE_CLK);
      #1 t++;
      if (WAKE_STATE !== prev) begin
        if (ns < 16) seq[ns] = int'(WAKE_STATE);
        ns++;
      end
      prev = WAKE_STATE;
      bg[WAKE_STATE[2:0]] = bg[WAKE_STATE[2:0]] | BANDGAP_EN;
      rc[WAKE_STATE[2:0]] = rc[WAKE_STATE[2:0]] | FAST_RC_EN;
      chg[WAKE_STATE[2:0]] = chg[WAKE_STATE[2:0]] | CONVERTER_CHARGE;
      trk[WAKE_STATE[2:0]] = trk[WAKE_STATE[2:0]] | REF_TRACK;
      hld[WAKE_STATE[2:0]] = hld[WAKE_STATE[2:0]] | REF_HOLD;
      if (BROWNOUT_SAMPLING_CLOCK !== bodp) begin
        if (last_tog >= 0 && gap == 0) gap = t - last_tog;
        last_tog = t;
        bodp = BROWNOUT_SAMPLING_CLOCK;
      end
    end while (!(ns > 0 && prev === 5'h00) && t < 20000);
    if (t >= 20000) begin
      bad_count++;
      $display("[FAIL] periodic wake return expected state 00 seen %h", prev);
      conclude();
    end
    chk("wake state count", 32'd8, 32'(ns));
    for (int i = 0; i < ns && i < 8; i++) begin
      chk("wake state order", 32'((i + 1) % 8), 32'(seq[i]));
    end
    chk("bandgap in first state", 32'd1, 32'(bg[1]));
    chk("fast rc in clock state", 32'd1, 32'(rc[2]));
    chk("brown-out clock half period", 32'(BOD_HALF_CYCLES), 32'(gap));
    chk("charge in converter state", 32'(exp_chg), 32'(chg[4]));
    chk("charge before converter state", 32'd0, 32'(chg[3:0]));
    chk("reference track", 32'(exp_ref), 32'(trk[5]));
    chk("reference hold", 32'(exp_ref), 32'(hld[6]));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    RST = 1'b1;
    ADDR = 4'h0;
    WDATA = 32'h0000_0000;
    WR = 1'b0;
    RD = 1'b0;
    WAKE_PIN = 1'b0;
    BOD_FAIL_PIN = 1'b0;
    sleep_req = 1'b0;
    bad_count = 0;
    n_checks = 0;
    lp_edges = 0;
    repeat (3) @(posedge CORE_CLK);
    #1 chk("processor held in reset", 32'd0, 32'(CPU_RUN));
    @(posedge CORE_CLK) RST <= 1'b0;
    e0 = lp_edges;
    rd(OFS_SLEEP_PERIOD, d);
    chk("sleep period reset", 32'h0000_0000, d);
    rd(4'h2, d);
    chk("unmapped read", 32'h0000_0000, d);
    wait_for(0, 1'b1, n);
    chk("power-up ticks", 32'(LDO_SETTLE_TICKS), 32'(lp_edges - e0));
    chk("boot rom at zero", 32'd0, 32'(REMAP_RAM));
    chk("fast rc with processor", 32'd1, 32'(FAST_RC_EN));
    wr(OFS_CONV_CTRL, 32'(CONV_MODE_ACTIVE));
    repeat (2) @(posedge CORE_CLK);
    #1 chk("converter active", 32'd1, 32'(CONVERTER_ACTIVE));
    wr(OFS_CONV_CTRL, 32'(CONV_MODE_SLEEP));
    wr(OFS_SLEEP_PERIOD, 32'h0000_0003);
    wr(OFS_POWER_CONFIG, 32'h0000_000F);
    wr(4'h6, 32'hFFFF_FFFF);
    rd(OFS_CONV_CTRL, d);
    chk("mode after unmapped write", 32'(CONV_MODE_SLEEP), d);
    rd(OFS_POWER_CONFIG, d);
    chk("power config", 32'h0000_000F, d);
    @(posedge CORE_CLK) sleep_req <= 1'b1;
    @(posedge CORE_CLK) sleep_req <= 1'b0;
    #1 chk("sleep instruction issued", 32'd1, 32'(WFI_PULSE));
    wait_for(1, 1'b1, n);
    chk("cycles to low-power clock", 32'(WFI_TO_LP_CYCLES), 32'(n));
    e0 = lp_edges;
    repeat (2) @(posedge CORE_CLK);
    #1 chk("retention regulators", 32'h7, 32'({SYS_RET_EN, IO_RET_A_EN, IO_RET_B_EN}));
    wait_for(2, 1'b0, n);
    chk("entry ticks", 32'(ENTRY_LATENCY_TICKS), 32'(lp_edges - e0));
    @(posedge CORE_CLK) BOD_FAIL_PIN <= 1'b1;
    watch_wake(1'b1, 1'b1);
    rd(OFS_STATUS, d);
    chk("brown-out seen", 32'd1, 32'(d[ST_BOD_SEEN]));
    @(posedge CORE_CLK) BOD_FAIL_PIN <= 1'b0;
    wr(OFS_STATUS, 32'h0000_0020);
    rd(OFS_STATUS, d);
    chk("brown-out cleared", 32'd0, 32'(d[ST_BOD_SEEN]));
    wr(OFS_POWER_CONFIG, 32'h0000_0001);
    wr(OFS_CONV_CTRL, 32'(CONV_MODE_ACTIVE));
    watch_wake(1'b0, 1'b0);
    wr(OFS_SLEEP_PERIOD, 32'h0000_0000);
    // A pulse shorter than the filter window must not wake the processor.
    @(posedge CORE_CLK) WAKE_PIN <= 1'b1;
    repeat (LPH / 2) @(posedge CORE_CLK);
    WAKE_PIN <= 1'b0;
    repeat (LPH * 20) @(posedge CORE_CLK);
    #1 chk("short wake ignored", 32'd0, 32'(CPU_RUN));
    chk("no periodic wake at period zero", 32'd0, 32'(WAKE_STATE));
    @(posedge CORE_CLK) WAKE_PIN <= 1'b1;
    wait_for(0, 1'b1, n);
    chk("fast rc at wake hand-over", 32'd1, 32'(FAST_RC_EN));
    chk("ram at zero after wake", 32'd1, 32'(REMAP_RAM));
    chk("core regulator after wake", 32'd1, 32'(CORE_REG_EN));
    @(posedge CORE_CLK) WAKE_PIN <= 1'b0;
    rd(OFS_STATUS, d);
    chk("remap status", 32'd1, 32'(d[ST_REMAP]));
    chk("wake within limit", 32'd0, 32'(d[ST_WAKE_TIMEOUT]));
    conclude();
  end
endmodule
`default_nettype wire
